/* core/spflag_readout.sv */
// Serial status readout: 16-bit frames, latched fault pages and live pages.
// Assumes the host runs SPI mode 0 with SCLK below one eighth of SYS_CLK.
`timescale 1ns/1ns
`default_nettype none
`include "spflag_consts.svh"

// Functional notes
// R1 - Command kind 11 selects the latched failure page of the addressed unit.
// R2 - Command kind 00 returns live state such as pin levels, not latched flags.
// R3 - Bits 13..9 address the unit: supply 0x0F up to safety 0x12.
// R4 - Host drives bit 8 high as a read marker, never parity.
// R5 - No parity check and no parity error raised for status reads.
// R6 - Flags latch on fault, clear on page read only after fault ends.
// R7 - Safety pages report interrupt, reset, debug resistor, supply and watchdog flags.
// R8 - Live safety page returns option bit, two part bits, five revision bits.
// R9 - Supply faults must persist over 100 us before their flag sets; the code filters only supply page 0, except its bit 5.
// R10 - Live read 0x2780 returns first LIN state and wake enable.
// R11 - Bit 7 picks the page; host sends bits 6..0 as zero.
module spflag_readout #(
    parameter int         FILT_CYCLES = `SPF_FILT_CYCLES,
    parameter logic [1:0] PART_NUM    = 2'h2,
    parameter logic [4:0] REVISION    = 5'h05
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    input  wire logic       SCLK,
    input  wire logic       CSN,
    input  wire logic       MOSI,
    output var  logic       MISO_OUT,
    output var  logic       MISO_OE,
    input  wire logic [7:0] SUPPLY_LO_FAULT,
    input  wire logic [7:0] SUPPLY_HI_FAULT,
    input  wire logic [7:0] BUS_XCVR_FAULT,
    input  wire logic [7:0] BUS_WIRE_FAULT,
    input  wire logic [7:0] PIN_LINK_FAULT,
    input  wire logic [7:0] WAKEUP_EVENT,
    input  wire logic [7:0] IRQ_RESET_FAULT,
    input  wire logic [7:0] RESET_HIST_FAULT,
    input  wire logic [2:0] BUS_LIVE_STATE,
    input  wire logic [3:0] PIN_LIVE_LEVEL,
    input  wire logic       LIN1_LIVE_STATE,
    input  wire logic       LIN1_WAKE_EN,
    input  wire logic       VDD_OPTION
);

    // PART_NUM and REVISION defaults are arbitrary values

    initial
    begin
        if (FILT_CYCLES < 1)
            $error("spflag_readout: filter needs at least one cycle");
    end

    // Decode one received command into a page selection
    function automatic spflag_pkg::spflag_sel_s spf_decode(input logic [15:0] cmd);
        spflag_pkg::spflag_sel_s s;
        logic [4:0]              a;
        s = '0;
        a = cmd[`SPF_CMD_ADDR_HI:`SPF_CMD_ADDR_LO]; // R3
        // Bit 8 only marks a read; it is never checked as parity
        if (!cmd[`SPF_CMD_MARK_BIT])
            s = '0; // R5
        else if (cmd[`SPF_CMD_KIND_HI:`SPF_CMD_KIND_LO] == `SPF_KIND_FAIL &&
                 a >= `SPF_ADDR_SUPPLY && a <= `SPF_ADDR_SAFE)
        begin
            s.ok   = 1'b1; // R1
            s.live = 1'b0;
            s.idx  = {2'((a - `SPF_ADDR_SUPPLY)), cmd[`SPF_CMD_PAGE_BIT]}; // R11
        end
        else if (cmd[`SPF_CMD_KIND_HI:`SPF_CMD_KIND_LO] == `SPF_KIND_LIVE &&
                 cmd[`SPF_CMD_PAGE_BIT] && a >= `SPF_ADDR_BUS && a <= `SPF_ADDR_LIN1)
        begin
            s.ok   = 1'b1; // R2
            s.live = 1'b1;
            s.idx  = 3'((a - `SPF_ADDR_BUS));
        end
        return s;
    endfunction : spf_decode

    // Pin synchronisers; stage one feeds stage two only
    logic [2:0]  pin_s1;
    logic [2:0]  pin_s2;
    logic [2:0]  pin_s3;
    logic [63:0] flt_s1;
    logic [63:0] flt_s2;
    logic [9:0]  live_s1;
    logic [9:0]  live_s2;

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pin_s1  <= 3'h1;
            pin_s2  <= 3'h1;
            pin_s3  <= 3'h1;
            flt_s1  <= '0;
            flt_s2  <= '0;
            live_s1 <= '0;
            live_s2 <= '0;
        end
        else
        begin
            pin_s1  <= {SCLK, MOSI, CSN};
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            flt_s1  <= {RESET_HIST_FAULT, IRQ_RESET_FAULT, WAKEUP_EVENT, PIN_LINK_FAULT,
                        BUS_WIRE_FAULT, BUS_XCVR_FAULT, SUPPLY_HI_FAULT, SUPPLY_LO_FAULT};
            flt_s2  <= flt_s1;
            live_s1 <= {VDD_OPTION, LIN1_WAKE_EN, LIN1_LIVE_STATE, PIN_LIVE_LEVEL,
                        BUS_LIVE_STATE};
            live_s2 <= live_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic mosi_bit;
    logic cs_low;

    // Edges from stage two against stage three
    assign sclk_rise = pin_s2[2] & ~pin_s3[2];
    assign sclk_fall = ~pin_s2[2] & pin_s3[2];
    assign cs_fall   = ~pin_s2[0] & pin_s3[0];
    assign cs_rise   = pin_s2[0] & ~pin_s3[0];
    assign mosi_bit  = pin_s2[1];
    assign cs_low    = ~pin_s2[0];

    // Fault flag bank, page p in bits 8p+7..8p
    logic [63:0] flags;
    logic [63:0] clr_r;
    logic [63:0] clr_nxt;

    spflag_latch #(
        .WIDTH       (64),
        .FILT_CYCLES (FILT_CYCLES),
        .FILT_MASK   (`SPF_FILT_MASK)
    ) u_latch (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .cond  (flt_s2), // R7
        .clr   (clr_r),
        .flags (flags)
    );

    // Summary byte: one bit per flag page, sent ahead of each answer
    logic [7:0] summary;
    always_comb
    begin
        for (int p = 0; p < 8; p++)
            summary[p] = |flags[p*8 +: 8];
    end

    spflag_pkg::spflag_state_e state_r;
    spflag_pkg::spflag_state_e state_nxt;
    logic [15:0]               rx_r;
    logic [15:0]               rx_nxt;
    logic [15:0]               tx_r;
    logic [15:0]               tx_nxt;
    logic [4:0]                cnt_r;
    logic [4:0]                cnt_nxt;
    logic [7:0]                ans_r;
    logic [7:0]                ans_nxt;
    logic                      miso_r;
    logic                      miso_nxt;
    logic                      oe_r;
    spflag_pkg::spflag_sel_s   sel;
    logic [7:0]                live_byte;

    assign sel = spf_decode(rx_r);

    // Live page contents, picked by unit
    always_comb
    begin
        live_byte = 8'h00;
        if (sel.idx == 3'h0)
            live_byte = {live_s2[2:0], 5'h00}; // R2
        else if (sel.idx == 3'h1)
            live_byte = {1'b0, live_s2[6], 1'b0, live_s2[5], 1'b0, live_s2[4],
                         1'b0, live_s2[3]};
        else if (sel.idx == 3'h2)
            live_byte = {live_s2[9], PART_NUM, REVISION}; // R8
        else if (sel.idx == 3'h3)
            live_byte = {live_s2[7], live_s2[8], 6'h00}; // R10
    end

    // Frame engine; the answer to a command goes out in the next frame
    always_comb
    begin
        state_nxt = state_r;
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        cnt_nxt   = cnt_r;
        ans_nxt   = ans_r;
        miso_nxt  = miso_r;
        clr_nxt   = '0;
        case (state_r)
            spflag_pkg::SPF_IDLE:
            begin
                if (cs_fall)
                begin
                    tx_nxt    = {summary, ans_r};
                    miso_nxt  = summary[7];
                    cnt_nxt   = 5'h00;
                    state_nxt = spflag_pkg::SPF_SHIFT;
                end
            end
            spflag_pkg::SPF_SHIFT:
            begin
                if (cs_rise)
                    // Short or long frames are dropped whole
                    state_nxt = (cnt_r == `SPF_FRAME_BITS) ? spflag_pkg::SPF_DONE
                                                           : spflag_pkg::SPF_IDLE;
                else if (sclk_rise)
                begin
                    rx_nxt = {rx_r[14:0], mosi_bit};
                    if (cnt_r != 5'h1F)
                        cnt_nxt = cnt_r + 5'h01;
                end
                else if (sclk_fall)
                begin
                    tx_nxt   = {tx_r[14:0], 1'b0};
                    miso_nxt = tx_r[14];
                end
            end
            spflag_pkg::SPF_DONE:
            begin
                // Snapshot now, clear through clr_r one cycle later; a new set wins the clear
                if (!sel.ok)
                    ans_nxt = `SPF_ANSWER_RST; // R3
                else if (sel.live)
                    ans_nxt = live_byte; // R2
                else
                begin
                    ans_nxt = flags[sel.idx*8 +: 8]; // R1
                    clr_nxt[sel.idx*8 +: 8] = 8'hFF; // R6
                end
                state_nxt = spflag_pkg::SPF_IDLE;
            end
            default:
                state_nxt = spflag_pkg::SPF_IDLE;
        endcase
    end

    // Frame registers
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_r <= spflag_pkg::SPF_IDLE;
            rx_r    <= `SPF_FRAME_RST;
            tx_r    <= `SPF_FRAME_RST;
            cnt_r   <= 5'h00;
            ans_r   <= `SPF_ANSWER_RST;
            miso_r  <= 1'b0;
            oe_r    <= 1'b0;
            clr_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            rx_r    <= rx_nxt;
            tx_r    <= tx_nxt;
            cnt_r   <= cnt_nxt;
            ans_r   <= ans_nxt;
            miso_r  <= miso_nxt;
            oe_r    <= cs_low;
            clr_r   <= clr_nxt;
        end
    end

    assign MISO_OUT = miso_r;
    assign MISO_OE  = oe_r;

    // A finished frame in the decode cycle
    sequence s_done;
        state_r == spflag_pkg::SPF_DONE;
    endsequence

    property p_fail_page;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r == 16'hE500)) |=> (ans_r == $past(flags[55:48]));
    endproperty
    a_fail_page: assert property (p_fail_page) // R7
        else $error("safety failure page not returned");

    property p_fail_hi;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r == 16'hDF80)) |=> (ans_r == $past(flags[15:8]));
    endproperty
    a_fail_hi: assert property (p_fail_hi) // R1
        else $error("supply second page not returned");

    property p_ident;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r == 16'h2580)) |=> (ans_r[6:0] == {PART_NUM, REVISION});
    endproperty
    a_ident: assert property (p_ident) // R8
        else $error("identity byte wrong");

    property p_lin1;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r == 16'h2780)) |=> (ans_r[5:0] == 6'h00 && ans_r[7] == $past(live_s2[7]));
    endproperty
    a_lin1: assert property (p_lin1) // R10
        else $error("first LIN live page wrong");

    property p_no_mark;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and !rx_r[8]) |=> (ans_r == 8'h00 && clr_r == 64'h0);
    endproperty
    a_no_mark: assert property (p_no_mark) // R5
        else $error("command without read marker acted on");

    property p_bad_addr;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r[13:9] < 5'h0F)) |=> (ans_r == 8'h00);
    endproperty
    a_bad_addr: assert property (p_bad_addr) // R3
        else $error("unmapped unit answered");

    property p_live_no_clear;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r[15:14] == 2'h0)) |=> (clr_r == 64'h0);
    endproperty
    a_live_no_clear: assert property (p_live_no_clear) // R2
        else $error("live read cleared flags");

    property p_clear_pulse;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (s_done and (rx_r == 16'hE100)) |=> (clr_r[23:16] == 8'hFF) ##1 (clr_r == 64'h0);
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) // R6
        else $error("page clear not a single pulse");

endmodule : spflag_readout

`default_nettype wire

/* core/spflag_consts.svh */
// Constants of the serial flag readout: command fields, unit addresses, timing.
// Included by bare name; holds definitions only.
`ifndef SPFLAG_CONSTS_SVH
`define SPFLAG_CONSTS_SVH

// Command field positions
`define SPF_CMD_KIND_HI     15
`define SPF_CMD_KIND_LO     14
`define SPF_CMD_ADDR_HI     13
`define SPF_CMD_ADDR_LO     9
`define SPF_CMD_MARK_BIT    8
`define SPF_CMD_PAGE_BIT    7
`define SPF_FRAME_BITS      5'h10

// Command kinds
`define SPF_KIND_FAIL       2'h3
`define SPF_KIND_LIVE       2'h0

// Unit addresses
`define SPF_ADDR_SUPPLY     5'h0F
`define SPF_ADDR_BUS        5'h10
`define SPF_ADDR_PIN        5'h11
`define SPF_ADDR_SAFE       5'h12
`define SPF_ADDR_LIN1       5'h13

// Reset values
`define SPF_ANSWER_RST      8'h00
`define SPF_FRAME_RST       16'h0000

// Fault persistence filter: 100 us at a 10 ns clock, rounded up
`define SPF_FILT_TIME_NS    100000
`define SPF_CLK_PERIOD_NS   10
`define SPF_FILT_CYCLES     ((`SPF_FILT_TIME_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)

// Pages whose flags wait for the filter: supply page 0 except its thermal bit
`define SPF_FILT_MASK       64'h0000_0000_0000_00DF

`endif

/* core/spflag_pkg.sv */
// Types shared by the serial flag readout modules.
// Assumes the constants header is compiled alongside.
package spflag_pkg;

    // Serial frame state, Gray coded along idle, shift, done
    typedef enum logic [1:0] {
        SPF_IDLE  = 2'b00,
        SPF_SHIFT = 2'b01,
        SPF_DONE  = 2'b11
    } spflag_state_e;

    // Result of decoding one command
    typedef struct packed {
        logic       ok;
        logic       live;
        logic [2:0] idx;
    } spflag_sel_s;

endpackage : spflag_pkg

/* core/spflag_latch.sv */
// Bank of latched fault flags with optional persistence filter per bit.
// Assumes fault conditions are already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
`include "spflag_consts.svh"

module spflag_latch #(
    parameter int          WIDTH       = 64,
    parameter int          FILT_CYCLES = `SPF_FILT_CYCLES,
    parameter logic [63:0] FILT_MASK   = `SPF_FILT_MASK
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic [WIDTH-1:0] clr,
    output var  logic [WIDTH-1:0] flags
);

    localparam int CW = $clog2(FILT_CYCLES + 2);
    localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYCLES);

    initial
    begin
        if (WIDTH < 1 || WIDTH > 64 || FILT_CYCLES < 1)
            $error("spflag_latch: unsupported parameters");
    end

    logic [CW-1:0]    cnt_r   [WIDTH];
    logic [CW-1:0]    cnt_nxt [WIDTH];
    logic [WIDTH-1:0] flag_r;
    logic [WIDTH-1:0] flag_nxt;
    logic [WIDTH-1:0] hit;

    // Count persistence; set beats a clear in the same cycle
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (!cond[i])
                cnt_nxt[i] = '0;
            else if (cnt_r[i] <= FILT_MAX)
                cnt_nxt[i] = cnt_r[i] + CW'(1);
            else
                cnt_nxt[i] = cnt_r[i];
            // Filtered bits need more than the filter time of steady fault
            hit[i] = FILT_MASK[i] ? (cond[i] && cnt_r[i] >= FILT_MAX) : cond[i]; // R9
            // Clear only once the fault has gone away
            flag_nxt[i] = hit[i] | (flag_r[i] & ~(clr[i] & ~cond[i])); // R6
        end
    end

    // Flag and counter registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_r <= '0;
            for (int i = 0; i < WIDTH; i++)
                cnt_r[i] <= '0;
        end
        else
        begin
            flag_r <= flag_nxt;
            for (int i = 0; i < WIDTH; i++)
                cnt_r[i] <= cnt_nxt[i];
        end
    end

    assign flags = flag_r;

    // A flag whose fault persists survives any clear
    property p_hold_while_fault;
        @(posedge clk) disable iff (!rst_n)
        (flag_r[0] && cond[0]) |=> flag_r[0];
    endproperty
    a_hold_while_fault: assert property (p_hold_while_fault) // R6
        else $error("flag cleared while fault still present");

    // A clear after recovery drops the flag unless it sets again
    property p_clear_on_read;
        @(posedge clk) disable iff (!rst_n)
        (flag_r[1] && clr[1] && !cond[1]) |=> !flag_r[1];
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) // R6
        else $error("flag not cleared by read after recovery");

    // Filtered bit does not set before persistence is reached
    property p_filter_set;
        @(posedge clk) disable iff (!rst_n)
        (!flag_r[0] && cond[0] && cnt_r[0] < FILT_MAX && FILT_MASK[0]) |=> !flag_r[0];
    endproperty
    a_filter_set: assert property (p_filter_set) // R9
        else $error("filtered flag set before persistence time");

endmodule : spflag_latch

`default_nettype wire

/* bench/spflag_host_model.sv */
// Host serial master model: SPI mode 0 frames of up to 16 bits, MSB first.
// Assumes the bench calls xfer by hierarchical name, one frame at a time.
`timescale 1ns/1ns
`default_nettype none

module spflag_host_model #(
    parameter int HALF = 5
) (
    input  wire logic clk,
    input  wire logic miso,
    output var  logic sclk,
    output var  logic csn,
    output var  logic mosi
);

    // Idle bus: clock low, frame deselected
    initial
    begin
        sclk = 1'b0;
        csn  = 1'b1;
        mosi = 1'b0;
    end

    // One frame; every pin changes just after a clock edge, reply sampled on SCLK rise
    task automatic xfer(input logic [15:0] cmd, input int nb, output logic [15:0] resp);
        resp = 16'h0000;
        @(posedge clk);
        csn <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < nb; i++)
        begin
            mosi <= cmd[15 - i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            resp = {resp[14:0], miso};
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        csn  <= 1'b1;
        mosi <= ~mosi; // Released line must not keep the last bit
        repeat (HALF + 2) @(posedge clk);
    endtask : xfer

endmodule : spflag_host_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the serial flag readout: pages read over 16-bit frames.
// Assumes the host model drives the serial pins and the bench drives fault inputs.
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_top;
    localparam logic [1:0]  PART = 2'h1;  // Arbitrary part code
    localparam logic [4:0]  REV  = 5'h0A; // Arbitrary revision code
    localparam logic [15:0] FAIL_CMD [8] = '{16'hDF00, 16'hDF80, 16'hE100, 16'hE180,
                                             16'hE300, 16'hE380, 16'hE500, 16'hE580};

    logic        SYS_CLK;
    logic        RESETN;
    logic        SCLK;
    logic        CSN;
    logic        MOSI;
    logic        MISO_OUT;
    logic        MISO_OE;
    logic        miso_w;
    logic [7:0]  flt [8];
    logic [2:0]  bus_live;
    logic [3:0]  pin_live;
    logic        lin_st;
    logic        lin_wk;
    logic        vdd_opt;
    logic [15:0] resp;
    int          bad_count;
    int          n_tests;

    // Undriven MISO shows the inverse, so a stale bit never reads as good
    assign miso_w = MISO_OE ? MISO_OUT : ~MISO_OUT;

    initial SYS_CLK = 1'b0;
    always #5 SYS_CLK = ~SYS_CLK;

    spflag_host_model host_u (
        .clk  (SYS_CLK),
        .miso (miso_w),
        .sclk (SCLK),
        .csn  (CSN),
        .mosi (MOSI)
    );

    spflag_readout #(
        .FILT_CYCLES (8),
        .PART_NUM    (PART),
        .REVISION    (REV)
    ) dut_u (
        .SYS_CLK          (SYS_CLK),
        .RESETN           (RESETN),
        .SCLK             (SCLK),
        .CSN              (CSN),
        .MOSI             (MOSI),
        .MISO_OUT         (MISO_OUT),
        .MISO_OE          (MISO_OE),
        .SUPPLY_LO_FAULT  (flt[0]),
        .SUPPLY_HI_FAULT  (flt[1]),
        .BUS_XCVR_FAULT   (flt[2]),
        .BUS_WIRE_FAULT   (flt[3]),
        .PIN_LINK_FAULT   (flt[4]),
        .WAKEUP_EVENT     (flt[5]),
        .IRQ_RESET_FAULT  (flt[6]),
        .RESET_HIST_FAULT (flt[7]),
        .BUS_LIVE_STATE   (bus_live),
        .PIN_LIVE_LEVEL   (pin_live),
        .LIN1_LIVE_STATE  (lin_st),
        .LIN1_WAKE_EN     (lin_wk),
        .VDD_OPTION       (vdd_opt)
    );

    // Distinct nonzero pattern for each fail page
    function automatic logic [7:0] pat(input int i);
        return 8'h5A ^ (8'h11 * 8'(i));
    endfunction : pat

    // Answer is pipelined: exp is the answer to the previous full frame
    task automatic frame(input logic [15:0] cmd, input logic [7:0] exp);
        host_u.xfer(cmd, 16, resp);
        `CHK("answer byte", exp, resp[7:0])
        `CHK("miso released", 1'b0, MISO_OE)
    endtask : frame

    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial
    begin
        RESETN    = 1'b0;
        flt       = '{default: 8'h00};
        bus_live  = 3'b101;
        pin_live  = 4'b1001;
        lin_st    = 1'b0;
        lin_wk    = 1'b1;
        vdd_opt   = 1'b1;
        bad_count = 0;
        n_tests   = 0;
        repeat (3) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        frame(16'h2580, 8'h00);
        `CHK("summary after reset", 8'h00, resp[15:8])
        frame(16'h2580, {vdd_opt, PART, REV});
        $display("test identity done");
        // Long faults on every page, gone before any read
        for (int i = 0; i < 8; i++)
            flt[i] <= pat(i);
        repeat (20) @(posedge SYS_CLK);
        for (int i = 0; i < 8; i++)
            flt[i] <= 8'h00;
        repeat (4) @(posedge SYS_CLK);
        for (int k = 0; k < 8; k++)
        begin
            frame(FAIL_CMD[k], (k == 0) ? 8'hAA : pat(k - 1));
            `CHK("page summary", 8'hFF << k, resp[15:8])
        end
        frame(16'hDF00, pat(7));
        `CHK("summary cleared", 8'h00, resp[15:8])
        frame(16'h2180, 8'h00);
        $display("test latch done");
        frame(16'h2380, 8'hA0);
        frame(16'h2780, 8'h41);
        // Refused and short frames must neither answer nor clear
        flt[1] <= 8'h08;
        repeat (20) @(posedge SYS_CLK);
        flt[1] <= 8'h00;
        host_u.xfer(16'hDF80, 8, resp);
        frame(16'hDE80, 8'h40);
        frame(16'h5F80, 8'h00);
        frame(16'hFF80, 8'h00);
        frame(16'hC180, 8'h00);
        frame(16'h2500, 8'h00);
        frame(16'hDF80, 8'h00);
        frame(16'hE300, 8'h08);
        flt[2] <= 8'h04;
        repeat (10) @(posedge SYS_CLK);
        frame(16'hE100, 8'h00);
        $display("test refusal done");
        // Flag held while its fault persists
        frame(16'hE100, 8'h04);
        flt[2] <= 8'h00;
        repeat (10) @(posedge SYS_CLK);
        frame(16'hE100, 8'h04);
        frame(16'hDF00, 8'h04);
        $display("test sticky done");
        // Short pulse: unfiltered bit sets, filtered bit does not
        flt[0] <= 8'h21;
        repeat (4) @(posedge SYS_CLK);
        flt[0] <= 8'h00;
        repeat (10) @(posedge SYS_CLK);
        frame(16'hDF00, 8'h00);
        frame(16'h2580, 8'h20);
        $display("test filter done");
        tally_and_finish();
    end

    // Watchdog: about 30 frames of under 200 cycles each
    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        tally_and_finish();
    end

endmodule : tb_top
`undef CHK
`default_nettype wire
